// [core/spg_top.sv]
`timescale 1ns/100ps
module spg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_in_n,
  input wire logic address_latch_enable,
  input wire logic chip_select_n,
  input wire logic [7:0] host_addr_data_in,
  input wire logic [7:0] host_address_in,
  input wire logic register_addressing_select,
  input wire logic interrupt_pending,
  output logic irq_out,
  output logic irq_oe_n,
  input wire logic line_timing_sync,
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe_n,
  input wire logic double_rate_clock_in,
  output logic double_rate_clock_out,
  output logic double_rate_clock_oe_n,
  output logic bit_rate_clock,
  input wire logic downstream_data_in,
  output logic downstream_data_out,
  output logic downstream_data_oe_n,
  input wire logic upstream_data_in,
  output logic upstream_data_out,
  output logic upstream_data_oe_n,
  output logic slot_strobe_one,
  output logic slot_strobe_two,
  input wire logic [3:0] side_port_pin_in,
  output logic [3:0] side_port_pin_out,
  output logic [3:0] side_port_pin_oe_n,
  output logic [2:0] channel_select
);
  logic [6:0] ctrl_r;
  logic [4:0] stb1_r;
  logic [4:0] stb2_r;
  logic [3:0] dir_r;
  logic [3:0] out_r;
  logic [3:0] in_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [6:0] rx_shift_r;
  logic [7:0] host_addr_r;
  logic host_mux_r;
  logic [31:0] prdata_r;
  logic dcl_gen_r;
  logic dcl_prev_r;
  logic bclk_r;
  logic fs_prev_r;
  logic fs_seen_r;
  logic [8:0] bit_cnt_r;
  logic [8:0] bit_cnt_nxt;
  logic bit_start_d_r;
  logic fs_out_r;
  logic stb1_out_r;
  logic stb2_out_r;
  logic tx_active_r;
  logic tx_bit_r;
  logic irq_out_r;
  logic irq_oe_n_r;
  logic [3:0] side_oe_n_r;
  spg_pkg::spg_mode_t mode;
  logic is_terminal;
  logic drive_link;
  logic te_tick;
  logic lt_tick;
  logic gen_tick;
  logic dcl_src;
  logic dcl_rise;
  logic bit_start;
  logic bit_mid;
  logic fs_rise;
  logic [8:0] frame_bits;
  logic [2:0] sel_ch;
  logic in_ch;
  logic [1:0] byte_in_ch;
  logic [2:0] bit_in_byte;
  logic data_slot;
  logic rx_bit;
  logic irq_pp;
  logic [3:0] gpio_en;
  logic setup_ph;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic host_capture;
  logic [7:0] host_addr_nxt;

  // mode decode
  assign mode = spg_pkg::spg_mode_t'(ctrl_r[spg_pkg::CTRL_MODE_LSB +: 2]);
  assign is_terminal = (mode == spg_pkg::SPG_TERMINAL);
  assign drive_link = is_terminal || (mode == spg_pkg::SPG_TRUNK);
  assign irq_pp = ctrl_r[spg_pkg::CTRL_PP_BIT];
  assign frame_bits = is_terminal ? spg_pkg::TE_FRAME_BITS : spg_pkg::LT_FRAME_BITS;

  // data clock rate generators; the trunk one restarts on line timing
  spg_phase_tick #(.INC(spg_pkg::TE_INC)) u_te_tick (
    .pclk(pclk),
    .presetn(presetn),
    .enable(is_terminal && reset_in_n),
    .restart(1'b0),
    .tick(te_tick)
  );
  spg_phase_tick #(.INC(spg_pkg::LT_INC)) u_lt_tick (
    .pclk(pclk),
    .presetn(presetn),
    .enable((mode == spg_pkg::SPG_TRUNK) && reset_in_n),
    .restart(line_timing_sync),
    .tick(lt_tick)
  );

  // clock source and edge detection
  assign gen_tick = is_terminal ? te_tick : lt_tick;
  assign dcl_src = drive_link ? dcl_gen_r : double_rate_clock_in;
  assign dcl_rise = dcl_src && !dcl_prev_r;
  assign bit_start = dcl_rise && !bclk_r;
  assign bit_mid = dcl_rise && bclk_r;
  assign fs_rise = frame_sync_in && !fs_prev_r;

  // bit counter: wraps itself when driving, follows frame sync when receiving
  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    if (bit_start)
    begin
      if (drive_link)
        bit_cnt_nxt = (bit_cnt_r == frame_bits - 9'h001) ? 9'h000 : bit_cnt_r + 9'h001;
      else if (fs_seen_r)
        bit_cnt_nxt = 9'h000;
      else if (bit_cnt_r != spg_pkg::BIT_CNT_MAX)
        bit_cnt_nxt = bit_cnt_r + 9'h001;
    end
  end

  // slot position decode
  assign byte_in_ch = bit_cnt_r[4:3];
  assign bit_in_byte = bit_cnt_r[2:0];
  assign sel_ch = is_terminal ? ctrl_r[spg_pkg::CTRL_CH_LSB +: 3] : side_port_pin_in[2:0];
  assign in_ch = !bit_cnt_r[8] && (bit_cnt_r[7:5] == sel_ch);
  assign data_slot = in_ch && (byte_in_ch == spg_pkg::DATA_BYTE);
  assign rx_bit = is_terminal || (mode == spg_pkg::SPG_TRUNK) ? downstream_data_in
                                                                : upstream_data_in;

  // strobe match: selected bytes and optionally the signalling bits
  function automatic logic stb_hit(input logic [4:0] cfg, input logic chan,
                                   input logic [1:0] byt, input logic [2:0] bitp);
    stb_hit = chan && (cfg[byt] || (cfg[spg_pkg::STB_DCH_BIT] && (byt == spg_pkg::DCH_BYTE)
                                    && (bitp < spg_pkg::DCH_BITS)));
  endfunction : stb_hit

  // link clocking state
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dcl_gen_r <= 1'b0;
      dcl_prev_r <= 1'b0;
      bclk_r <= 1'b0;
      fs_prev_r <= 1'b0;
      bit_start_d_r <= 1'b0;
    end
    else if (!reset_in_n)
    begin
      dcl_gen_r <= 1'b0;
      dcl_prev_r <= 1'b0;
      bclk_r <= 1'b0;
      fs_prev_r <= 1'b0;
      bit_start_d_r <= 1'b0;
    end
    else
    begin
      dcl_gen_r <= gen_tick ? !dcl_gen_r : dcl_gen_r;
      dcl_prev_r <= dcl_src;
      bclk_r <= dcl_rise ? !bclk_r : bclk_r;
      fs_prev_r <= frame_sync_in;
      bit_start_d_r <= bit_start;
    end

  // frame position and frame sync; a new sync beats the clear at bit start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bit_cnt_r <= 9'h000;
      fs_seen_r <= 1'b0;
      fs_out_r <= 1'b0;
    end
    else if (!reset_in_n)
    begin
      bit_cnt_r <= 9'h000;
      fs_seen_r <= 1'b0;
      fs_out_r <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      fs_seen_r <= fs_rise || (fs_seen_r && !bit_start);
      if (bit_start)
        fs_out_r <= drive_link && (bit_cnt_nxt == 9'h000);
    end

  // strobes and transmit bit, updated just after each bit start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stb1_out_r <= 1'b0;
      stb2_out_r <= 1'b0;
      tx_active_r <= 1'b0;
      tx_bit_r <= 1'b1;
    end
    else if (!reset_in_n)
    begin
      stb1_out_r <= 1'b0;
      stb2_out_r <= 1'b0;
      tx_active_r <= 1'b0;
      tx_bit_r <= 1'b1;
    end
    else if (bit_start_d_r)
    begin
      stb1_out_r <= stb_hit(stb1_r, in_ch, byte_in_ch, bit_in_byte);
      stb2_out_r <= stb_hit(stb2_r, in_ch, byte_in_ch, bit_in_byte);
      tx_active_r <= data_slot;
      tx_bit_r <= tx_r[3'h7 - bit_in_byte];
    end

  // receive byte sampled mid bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_shift_r <= 7'h00;
      rx_r <= 8'h00;
    end
    else if (!reset_in_n)
    begin
      rx_shift_r <= 7'h00;
      rx_r <= 8'h00;
    end
    else if (bit_mid && data_slot)
    begin
      rx_shift_r <= {rx_shift_r[5:0], rx_bit};
      if (bit_in_byte == 3'h7)
        rx_r <= {rx_shift_r, rx_bit};
    end

  // host port address capture, gated by chip select
  assign host_capture = !chip_select_n && (!host_mux_r || address_latch_enable);
  assign host_addr_nxt = host_mux_r ? host_addr_data_in :
                         register_addressing_select ? {7'h00, host_address_in[0]} :
                         host_address_in;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      host_mux_r <= 1'b0;
      host_addr_r <= 8'h00;
    end
    else if (!reset_in_n)
    begin
      host_mux_r <= 1'b0;
      host_addr_r <= 8'h00;
    end
    else
    begin
      host_mux_r <= host_mux_r || address_latch_enable;
      if (host_capture)
        host_addr_r <= host_addr_nxt;
    end

  // pin drivers: open drain only pulls low
  assign gpio_en = {1'b1, {3{is_terminal}}};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_out_r <= 1'b0;
      irq_oe_n_r <= 1'b1;
      side_oe_n_r <= 4'hF;
      in_r <= 4'h0;
    end
    else
    begin
      irq_out_r <= irq_pp && interrupt_pending && reset_in_n;
      irq_oe_n_r <= irq_pp ? !reset_in_n : !(interrupt_pending && reset_in_n);
      side_oe_n_r <= ~(gpio_en & dir_r & ~out_r);
      in_r <= side_port_pin_in;
    end

  // APB slave: read data captured in setup, zero wait states
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && reset_in_n;
  assign addr_hit = (paddr == spg_pkg::CTRL_OFS) || (paddr == spg_pkg::STB1_OFS) ||
                    (paddr == spg_pkg::STB2_OFS) || (paddr == spg_pkg::DIR_OFS) ||
                    (paddr == spg_pkg::OUT_OFS) || (paddr == spg_pkg::IN_OFS) ||
                    (paddr == spg_pkg::TX_OFS) || (paddr == spg_pkg::RX_OFS) ||
                    (paddr == spg_pkg::HOST_OFS);
  assign rd_mux = (paddr == spg_pkg::CTRL_OFS) ? {25'h0, ctrl_r} :
                  (paddr == spg_pkg::STB1_OFS) ? {27'h0, stb1_r} :
                  (paddr == spg_pkg::STB2_OFS) ? {27'h0, stb2_r} :
                  (paddr == spg_pkg::DIR_OFS) ? {28'h0, dir_r} :
                  (paddr == spg_pkg::OUT_OFS) ? {28'h0, out_r} :
                  (paddr == spg_pkg::IN_OFS) ? {28'h0, in_r} :
                  (paddr == spg_pkg::TX_OFS) ? {24'h0, tx_r} :
                  (paddr == spg_pkg::RX_OFS) ? {24'h0, rx_r} :
                  (paddr == spg_pkg::HOST_OFS) ? {22'h0, register_addressing_select,
                                                  host_mux_r, host_addr_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_r <= 32'h0;
    else if (setup_ph)
      prdata_r <= rd_mux;

  // software registers, held at their reset values while the reset pin is low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_r <= spg_pkg::CTRL_RST;
      stb1_r <= spg_pkg::STB_RST;
      stb2_r <= spg_pkg::STB_RST;
      dir_r <= spg_pkg::DIR_RST;
      out_r <= spg_pkg::OUT_RST;
      tx_r <= spg_pkg::TX_RST;
    end
    else if (!reset_in_n)
    begin
      ctrl_r <= spg_pkg::CTRL_RST;
      stb1_r <= spg_pkg::STB_RST;
      stb2_r <= spg_pkg::STB_RST;
      dir_r <= spg_pkg::DIR_RST;
      out_r <= spg_pkg::OUT_RST;
      tx_r <= spg_pkg::TX_RST;
    end
    else if (wr_en)
    begin
      if (paddr == spg_pkg::CTRL_OFS)
        ctrl_r <= pwdata[6:0];
      if (paddr == spg_pkg::STB1_OFS)
        stb1_r <= pwdata[4:0];
      if (paddr == spg_pkg::STB2_OFS)
        stb2_r <= pwdata[4:0];
      if (paddr == spg_pkg::DIR_OFS)
        dir_r <= pwdata[3:0];
      if (paddr == spg_pkg::OUT_OFS)
        out_r <= pwdata[3:0];
      if (paddr == spg_pkg::TX_OFS)
        tx_r <= pwdata[7:0];
    end

  // output wiring
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign irq_out = irq_out_r;
  assign irq_oe_n = irq_oe_n_r;
  assign frame_sync_out = fs_out_r;
  assign frame_sync_oe_n = !(drive_link && reset_in_n);
  assign double_rate_clock_out = dcl_gen_r;
  assign double_rate_clock_oe_n = !(drive_link && reset_in_n);
  assign bit_rate_clock = bclk_r;
  assign downstream_data_out = 1'b0;
  assign downstream_data_oe_n = !(tx_active_r && !tx_bit_r && !drive_link);
  assign upstream_data_out = 1'b0;
  assign upstream_data_oe_n = !(tx_active_r && !tx_bit_r && drive_link);
  assign slot_strobe_one = stb1_out_r;
  assign slot_strobe_two = stb2_out_r;
  assign side_port_pin_out = 4'h0;
  assign side_port_pin_oe_n = side_oe_n_r;
  assign channel_select = sel_ch;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence frame_wrap_s;
    drive_link && bit_start && (bit_cnt_r == frame_bits - 9'h001);
  endsequence
  sequence frame_start_s;
    (bit_cnt_r == 9'h000) ##1 fs_out_r;
  endsequence

  bclk_divide_a: assert property (reset_in_n && dcl_rise |=> bclk_r != $past(bclk_r))
    else $error("bit clock did not toggle on data clock edge");
  frame_wrap_a: assert property (reset_in_n ##0 frame_wrap_s |=> frame_start_s)
    else $error("frame did not wrap with sync");
  fs_follow_a: assert property (reset_in_n && !drive_link && fs_seen_r && bit_start
                                |=> bit_cnt_r == 9'h000)
    else $error("received frame sync not followed");
  irq_od_a: assert property (reset_in_n && !irq_pp && interrupt_pending ##1 !irq_pp |->
                             !irq_oe_n && !irq_out)
    else $error("open drain interrupt not pulled low");
  irq_pp_a: assert property (reset_in_n && irq_pp ##1 irq_pp |-> !irq_oe_n &&
                             irq_out == $past(interrupt_pending))
    else $error("push-pull interrupt level wrong");
  od_low_only_a: assert property (!$past(irq_pp) && !irq_oe_n |-> !irq_out)
    else $error("open drain request driven high");
  cs_ignore_a: assert property (reset_in_n && chip_select_n |=> $stable(host_addr_r))
    else $error("address captured without chip select");
  ale_latch_a: assert property (reset_in_n && host_mux_r && address_latch_enable
                                && !chip_select_n |=> host_addr_r == $past(host_addr_data_in))
    else $error("multiplexed address not latched");
  chan_pins_a: assert property (!is_terminal ##1 !is_terminal |-> side_oe_n_r[2:0] == 3'h7)
    else $error("channel select pins driven");
  reset_hold_a: assert property (!reset_in_n |-> frame_sync_oe_n ##1
                                 (ctrl_r == spg_pkg::CTRL_RST && irq_oe_n))
    else $error("state not held in reset");
  strobe_slot_a: assert property (slot_strobe_one |-> $past(in_ch, 1) || $past(in_ch, 2))
    else $error("strobe outside selected channel");
endmodule : spg_top

// [common/spg_pkg.sv]
// Functional notes
// - in multiplexed mode, address on shared lines is latched while strobe is high
// - the address strobe pin selects multiplexed or non-multiplexed host bus
// - host address capture needs chip select low; the address strobe sets multiplexed mode with chip select high too
// - pending interrupt asserts request pin, by default active low open drain
// - option makes the request pin active high push-pull
// - device is held in reset while the reset pin is low
// - addressing select 0 means direct, 1 means indirect register access
// - frame sync marks 8 kHz frames; driven or received depending on mode
// - frame data clock runs at twice the bit rate, 1.536 MHz in terminal mode
// - terminal mode bit clock equals data clock divided by 2
// - trunk mode bit clock is 1.536 MHz locked to line timing
// - network and line-side modes divide the incoming data clock by 2
// - downstream line carries downstream data through an open-drain driver
// - upstream line carries upstream data through an open-drain driver
// - two programmable strobes mark chosen time slots and/or signalling bits
// - terminal mode side pins 0 to 2 are register-controlled general I/O
// - other modes use side pins 0 to 2 as a 3-bit channel select
// - side pin 3 is general I/O read and set through registers
// - non-multiplexed indirect access uses only address bit zero
package spg_pkg;
  // link rates
  localparam longint PCLK_HZ = 25000000;
  localparam longint TE_DCL_HZ = 1536000;
  localparam longint LT_DCL_HZ = 3072000;
  localparam longint FRAME_HZ = 8000;
  localparam int ACC_W = 16;
  localparam logic [15:0] TE_INC = 16'((2 * TE_DCL_HZ * (longint'(1) << ACC_W)) / PCLK_HZ);
  localparam logic [15:0] LT_INC = 16'((2 * LT_DCL_HZ * (longint'(1) << ACC_W)) / PCLK_HZ);
  localparam logic [8:0] TE_FRAME_BITS = 9'(TE_DCL_HZ / 2 / FRAME_HZ);
  localparam logic [8:0] LT_FRAME_BITS = 9'(LT_DCL_HZ / 2 / FRAME_HZ);
  localparam logic [8:0] BIT_CNT_MAX = 9'h1FF;
  // signalling channel and data byte positions inside a channel
  localparam logic [1:0] DCH_BYTE = 2'h3;
  localparam logic [2:0] DCH_BITS = 3'h2;
  localparam logic [1:0] DATA_BYTE = 2'h0;
  // register offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STB1_OFS = 12'h004;
  localparam logic [11:0] STB2_OFS = 12'h008;
  localparam logic [11:0] DIR_OFS = 12'h00C;
  localparam logic [11:0] OUT_OFS = 12'h010;
  localparam logic [11:0] IN_OFS = 12'h014;
  localparam logic [11:0] TX_OFS = 12'h018;
  localparam logic [11:0] RX_OFS = 12'h01C;
  localparam logic [11:0] HOST_OFS = 12'h020;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PP_BIT = 2;
  localparam int CTRL_CH_LSB = 4;
  localparam int STB_DCH_BIT = 4;
  localparam int HOST_MUX_BIT = 8;
  localparam int HOST_IND_BIT = 9;
  // reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [4:0] STB_RST = 5'h00;
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [3:0] OUT_RST = 4'hF;
  localparam logic [7:0] TX_RST = 8'hFF;
  typedef enum logic [1:0] {SPG_TERMINAL, SPG_TRUNK, SPG_LINE_SIDE, SPG_NETWORK} spg_mode_t;
endpackage : spg_pkg

// [core/spg_phase_tick.sv]
`timescale 1ns/100ps
module spg_phase_tick #(
  parameter logic [15:0] INC = 16'h0001
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  output logic tick
);
  logic [15:0] acc_r;
  logic tick_r;
  logic [16:0] sum;

  // phase accumulator, carry out is the rate pulse
  assign sum = {1'b0, acc_r} + {1'b0, INC};
  assign tick = tick_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acc_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (restart || !enable)
    begin
      acc_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      acc_r <= sum[15:0];
      tick_r <= sum[16];
    end
endmodule : spg_phase_tick

// [tb/spg_peer_model.sv]
`timescale 1ns/100ps
// frame bus peer: makes data clock and frame sync while run is high
module spg_peer_model (
  input wire logic run,
  output logic dclk,
  output logic fs
);
  int n;
  // clock stands still at 0 outside run; 384 clock periods per frame
  initial
  begin
    dclk = 1'b0;
    fs = 1'b0;
    n = 0;
    forever
    begin
      // start off the pclk grid so no link edge meets a sampling edge
      wait (run);
      #0.1;
      while (run)
      begin
        #162.8 dclk = 1'b1;
        fs = (n == 0);
        n = (n + 1) % 384;
        #162.8 dclk = 1'b0;
      end
      fs = 1'b0;
    end
  end
endmodule : spg_peer_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, reset_in_n, strobe_in, sel_n, ras, pend, run, lts;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, rerr, irq_out, irq_oe_n, fs_out, fs_oe_n, dclk_in, fs_in;
  logic dclk_out, dclk_oe_n, bclk, dn_out, dn_oe_n, up_out, up_oe_n, s1, s2;
  logic [7:0] ad, ha;
  logic [3:0] pins, sp_out, sp_oe_n;
  logic [2:0] chsel;
  int failures, n_compared, cyc, nb, nd, c1, c2, cu, cdn;
  // device under test; released lines read high, data lines cross so each mode hears itself
  spg_top u_spg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_in_n(reset_in_n),
    .address_latch_enable(strobe_in), .chip_select_n(sel_n),
    .host_addr_data_in(ad), .host_address_in(ha),
    .register_addressing_select(ras), .interrupt_pending(pend),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .line_timing_sync(lts),
    .frame_sync_in(fs_in), .frame_sync_out(fs_out), .frame_sync_oe_n(fs_oe_n),
    .double_rate_clock_in(dclk_in), .double_rate_clock_out(dclk_out),
    .double_rate_clock_oe_n(dclk_oe_n), .bit_rate_clock(bclk),
    .downstream_data_in(up_oe_n ? 1'b1 : up_out), .downstream_data_out(dn_out),
    .downstream_data_oe_n(dn_oe_n), .upstream_data_in(dn_oe_n ? 1'b1 : dn_out),
    .upstream_data_out(up_out), .upstream_data_oe_n(up_oe_n),
    .slot_strobe_one(s1), .slot_strobe_two(s2), .side_port_pin_in(pins & sp_oe_n),
    .side_port_pin_out(sp_out), .side_port_pin_oe_n(sp_oe_n), .channel_select(chsel)
  );
  // far side of the frame bus
  spg_peer_model u_spg_peer_model (.run(run), .dclk(dclk_in), .fs(fs_in));
  // 25 MHz clock
  always #20 pclk = ~pclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // one register transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task t_regs;
    apb(1'b0, spg_pkg::CTRL_OFS, 32'h0);
    chk(rv, 32'(spg_pkg::CTRL_RST));
    apb(1'b0, spg_pkg::DIR_OFS, 32'h0);
    chk(rv, 32'(spg_pkg::DIR_RST));
    apb(1'b0, spg_pkg::OUT_OFS, 32'h0);
    chk(rv, 32'(spg_pkg::OUT_RST));
    apb(1'b0, spg_pkg::TX_OFS, 32'h0);
    chk(rv, 32'(spg_pkg::TX_RST));
    apb(1'b1, spg_pkg::STB2_OFS, 32'hFFFFFFFF);
    apb(1'b0, spg_pkg::STB2_OFS, 32'h0);
    chk(rv, 32'h1F);
    apb(1'b1, 12'h040, 32'h1);
    chk(32'(rerr), 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    chk({rv[30:0], rerr}, 32'h1);
  endtask : t_regs
  // address capture on the host pins in every bus type
  task t_host;
    wt(4);
    apb(1'b0, spg_pkg::HOST_OFS, 32'h0);
    chk(rv, 32'h0);
    sel_n <= 1'b0;
    wt(4);
    apb(1'b0, spg_pkg::HOST_OFS, 32'h0);
    chk(rv, 32'h05A);
    ras <= 1'b1;
    ha <= 8'hFF;
    wt(4);
    apb(1'b0, spg_pkg::HOST_OFS, 32'h0);
    chk(rv, 32'h201);
    ras <= 1'b0;
    strobe_in <= 1'b1;
    wt(4);
    strobe_in <= 1'b0;
    ad <= 8'h11;
    wt(4);
    apb(1'b0, spg_pkg::HOST_OFS, 32'h0);
    chk(rv, 32'h1C3);
    sel_n <= 1'b1;
  endtask : t_host
  task t_irq;
    pend <= 1'b1;
    wt(3);
    chk({irq_out, irq_oe_n}, 32'h0);
    pend <= 1'b0;
    wt(3);
    chk({irq_out, irq_oe_n}, 32'h1);
    apb(1'b1, spg_pkg::CTRL_OFS, 32'h4);
    pend <= 1'b1;
    wt(3);
    chk({irq_out, irq_oe_n}, 32'h2);
    pend <= 1'b0;
    wt(3);
    chk({irq_out, irq_oe_n}, 32'h0);
    apb(1'b1, spg_pkg::CTRL_OFS, 32'h0);
  endtask : t_irq
  task t_chan;
    pins <= 4'hA;
    for (int m = 0; m < 4; m++)
    begin
      run <= (m > 1);
      apb(1'b1, spg_pkg::CTRL_OFS, 32'h50 | 32'(m));
      wt(3);
      chk(32'(chsel), (m == 0) ? 32'h5 : 32'h2);
      chk({fs_oe_n, dclk_oe_n}, (m > 1) ? 32'h3 : 32'h0);
    end
  endtask : t_chan
  task t_gpio;
    apb(1'b1, spg_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, spg_pkg::DIR_OFS, 32'hA);
    apb(1'b1, spg_pkg::OUT_OFS, 32'h0);
    pins <= 4'hF;
    wt(3);
    chk({sp_out, sp_oe_n}, 32'h05);
    apb(1'b1, spg_pkg::OUT_OFS, 32'h2);
    wt(3);
    chk(32'(sp_oe_n), 32'h7);
    apb(1'b0, spg_pkg::IN_OFS, 32'h0);
    chk(rv, 32'h7);
    pins <= 4'h4;
    wt(3);
    apb(1'b0, spg_pkg::IN_OFS, 32'h0);
    chk(rv, 32'h4);
    apb(1'b1, spg_pkg::DIR_OFS, 32'h0);
  endtask : t_gpio
  task t_reset;
    apb(1'b1, spg_pkg::STB1_OFS, 32'hF);
    reset_in_n <= 1'b0;
    pend <= 1'b1;
    wt(3);
    apb(1'b1, spg_pkg::STB1_OFS, 32'h1F);
    apb(1'b0, spg_pkg::STB1_OFS, 32'h0);
    chk(rv, 32'h0);
    chk(32'(irq_oe_n), 32'h1);
    pend <= 1'b0;
    reset_in_n <= 1'b1;
    wt(2);
  endtask : t_reset
  // counts one whole frame between two frame sync rises
  task frame(input logic src);
    logic f, fp, dc, dp, bp;
    int k;
    k = 0;
    fp = 1'b1;
    dp = 1'b1;
    bp = 1'b1;
    {cyc, nb, nd, c1, c2, cu, cdn} = '0;
    while (k < 2)
    begin
      @(posedge pclk);
      f = src ? fs_in : fs_out;
      dc = src ? dclk_in : dclk_out;
      if (f && !fp) k++;
      if (k == 1)
      begin
        cyc++;
        nd += int'(dc && !dp);
        if (bclk && !bp)
        begin
          nb++;
          c1 += int'(s1);
          c2 += int'(s2);
          cu += int'(!up_oe_n);
          cdn += int'(!dn_oe_n);
        end
      end
      fp = f;
      dp = dc;
      bp = bclk;
    end
  endtask : frame
  task t_link;
    apb(1'b1, spg_pkg::STB1_OFS, 32'h1);
    apb(1'b1, spg_pkg::STB2_OFS, 32'h10);
    apb(1'b1, spg_pkg::TX_OFS, 32'h5A);
    pins <= 4'h8;
    for (int m = 0; m < 4; m++)
    begin
      run <= (m > 1);
      apb(1'b1, spg_pkg::CTRL_OFS, 32'(m));
      frame(m > 1);
      frame(m > 1);
      chk(32'(nb), (m == 0) ? 32'd96 : 32'd192);
      chk(32'(nd), 32'(2 * nb));
      chk(32'(cyc >= 3120 && cyc <= 3130), 32'h1);
      chk(32'(c1), 32'd8);
      chk(32'(c2), 32'd2);
      chk(32'(cu), (m > 1) ? 32'd0 : 32'd4);
      chk(32'(cdn), (m > 1) ? 32'd4 : 32'd0);
      apb(1'b0, spg_pkg::RX_OFS, 32'h0);
      chk(rv, 32'h5A);
      // holding line timing sync keeps the trunk data clock generator parked
      if (m == 1)
      begin
        lts <= 1'b1;
        wt(4);
        cu = int'(dclk_out);
        nd = 0;
        repeat (40)
        begin
          @(posedge pclk);
          nd += int'(dclk_out !== cu[0]);
        end
        chk(32'(nd), 32'h0);
        lts <= 1'b0;
      end
    end
    run <= 1'b0;
  endtask : t_link
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, strobe_in, ras, pend, run, lts} = '0;
    {reset_in_n, sel_n} = 2'h3;
    {paddr, pwdata, failures, n_compared} = '0;
    ad = 8'hC3;
    ha = 8'h5A;
    pins = 4'hF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_host();
    t_irq();
    t_chan();
    t_gpio();
    t_reset();
    t_link();
    complete_run();
  end
  // watchdog: whole run needs about 2 ms
  initial
  begin
    #3000000;
    failures++;
    complete_run();
  end
endmodule : tb
